// >>> qdwfd_regs.svh
// Purpose: named constants for the write frame decoder
// Assumes: 24-bit frames, bit 23 first field
// Notes: included by the qdwfd_channel and qdwfd_top modules
`ifndef QDWFD_REGS_SVH
`define QDWFD_REGS_SVH
`define QDWFD_RW_BIT 23
`define QDWFD_TADDR_HI 22
`define QDWFD_TADDR_LO 21
`define QDWFD_GRP_HI 20
`define QDWFD_GRP_LO 18
`define QDWFD_CH_HI 17
`define QDWFD_CH_LO 16
`define QDWFD_DATA_HI 15
`define QDWFD_CSEL_HI 15
`define QDWFD_CSEL_LO 13
`define QDWFD_CDATA_HI 12
`define QDWFD_GRP_DATA 3'h0
`define QDWFD_GRP_GAIN 3'h2
`define QDWFD_GRP_GAIN_ALL 3'h3
`define QDWFD_GRP_OFFS 3'h4
`define QDWFD_GRP_OFFS_ALL 3'h5
`define QDWFD_GRP_CLR 3'h6
`define QDWFD_GRP_CTRL 3'h7
`define QDWFD_CSEL_SLEW 3'h0
`define QDWFD_CSEL_MAIN 3'h1
`define QDWFD_CSEL_DACCTL 3'h2
`define QDWFD_CSEL_DCDC 3'h3
`define QDWFD_CSEL_SW 3'h4
`define QDWFD_GAIN_RST 16'hffff
`define QDWFD_OFFS_RST 16'h8000
`define QDWFD_CLR_RST 16'h0000
`define QDWFD_DATA_RST 16'h0000
`define QDWFD_MAIN_RST 16'h0000
`define QDWFD_MAIN_MASK 16'h1f70
`define QDWFD_MAIN_POLARITY 12
`define QDWFD_MAIN_READBACK 11
`define QDWFD_MAIN_WDOG 10
`define QDWFD_MAIN_TSEL_HI 9
`define QDWFD_MAIN_TSEL_LO 8
`define QDWFD_MAIN_SHORT 6
`define QDWFD_MAIN_OUTEN 5
`define QDWFD_MAIN_PWR 4
`define QDWFD_CTL13_RST 13'h0000
`define QDWFD_CLREN_BIT 0
`endif

// >>> qdwfd_pkg.sv
// Purpose: shared types of the write frame decoder
// Assumes: four channels of 16-bit registers
// Notes: constants live in qdwfd_regs.svh
package qdwfd_pkg;
    typedef logic [15:0] qdwfd_word_t;
    typedef logic [1:0] qdwfd_chan_t;
endpackage

// >>> qdwfd_channel.sv
// Purpose: one channel's register set
// Assumes: write strobes come from the frame decoder
// Notes: holds gain, offset, clear code, data, dac control and slew control
`timescale 1ns/1ps
`include "qdwfd_regs.svh"
module qdwfd_channel
    import qdwfd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // write strobes and data
    input wire logic wrData,
    input wire logic wrGain,
    input wire logic wrOffs,
    input wire logic wrClr,
    input wire logic wrDacCtl,
    input wire logic wrSlew,
    input wire qdwfd_pkg::qdwfd_word_t wrWord,
    // register contents
    output qdwfd_pkg::qdwfd_word_t dataVal,
    output qdwfd_pkg::qdwfd_word_t gainVal,
    output qdwfd_pkg::qdwfd_word_t offsVal,
    output qdwfd_pkg::qdwfd_word_t clrVal,
    output logic [12:0] dacCtlVal,
    output logic [12:0] slewVal
);
    import qdwfd_pkg::*;
    typedef struct packed {
        qdwfd_word_t data;
        qdwfd_word_t gain;
        qdwfd_word_t offs;
        qdwfd_word_t clr;
        logic [12:0] dacCtl;
        logic [12:0] slew;
    } qdwfd_chan_st_t;
    qdwfd_chan_st_t st_q, st_d;

    // next state of the channel registers
    always_comb begin
        st_d = st_q;
        if (wrData) st_d.data = wrWord;
        if (wrGain) st_d.gain = wrWord;
        if (wrOffs) st_d.offs = wrWord;
        if (wrClr) st_d.clr = wrWord;
        if (wrDacCtl) st_d.dacCtl = wrWord[`QDWFD_CDATA_HI:0];
        if (wrSlew) st_d.slew = wrWord[`QDWFD_CDATA_HI:0];
    end

    // register stage with reset values
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_q.data <= `QDWFD_DATA_RST;
            st_q.gain <= `QDWFD_GAIN_RST;
            st_q.offs <= `QDWFD_OFFS_RST;
            st_q.clr <= `QDWFD_CLR_RST;
            st_q.dacCtl <= `QDWFD_CTL13_RST;
            st_q.slew <= `QDWFD_CTL13_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign dataVal = st_q.data;
    assign gainVal = st_q.gain;
    assign offsVal = st_q.offs;
    assign clrVal = st_q.clr;
    assign dacCtlVal = st_q.dacCtl;
    assign slewVal = st_q.slew;
endmodule

// >>> qdwfd_top.sv
// Purpose: decode 24-bit write frames into channel and shared registers
// Assumes: frameValid is a one-cycle strobe from serial logic on mclk
// Notes: clear input and straps are pins and are synchronised here
//        channel outputs show two edges after the taking edge, shared ones one
`timescale 1ns/1ps
`include "qdwfd_regs.svh"
module qdwfd_top
    import qdwfd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // frame input
    input wire logic frameValid,
    input wire logic [23:0] frameWord,
    // pins
    input wire logic addressStrapHi,
    input wire logic addressStrapLo,
    input wire logic clearPin,
    // channel outputs, channel A in the low word
    output logic [63:0] chanOutCode,
    output logic [63:0] chanGain,
    output logic [63:0] chanOffset,
    output logic [63:0] chanDacCtl,
    output logic [63:0] chanSlew,
    // shared outputs
    output logic outputPolarityOption,
    output logic statusReadbackEnable,
    output logic watchdogEnableBit,
    output logic [1:0] timeoutSelect,
    output logic shortLimitSelect,
    output logic outputEnableAllChannels,
    output logic converterPowerAllChannels,
    output logic [12:0] converterCtl,
    output logic [12:0] softwareReg,
    output logic softwareWritePulse
);
    import qdwfd_pkg::*;
    typedef struct packed {
        logic [1:0] strapSync1;
        logic [1:0] strapSync2;
        logic clrSync1;
        logic clrSync2;
        qdwfd_word_t mainCtl;
        logic [12:0] dcdc;
        logic [12:0] sw;
        logic swPulse;
        logic [63:0] outCode;
        logic [63:0] gain;
        logic [63:0] offs;
        logic [63:0] dacCtl;
        logic [63:0] slew;
    } qdwfd_top_st_t;
    qdwfd_top_st_t st_q, st_d;

    logic [15:0] dataVal [4];
    logic [15:0] gainVal [4];
    logic [15:0] offsVal [4];
    logic [15:0] clrVal [4];
    logic [12:0] dacCtlVal [4];
    logic [12:0] slewVal [4];
    logic [3:0] wrData, wrGain, wrOffs, wrClr, wrDacCtl, wrSlew;

    // frame fields
    logic [2:0] grp;
    logic [2:0] csel;
    qdwfd_chan_t chan;
    qdwfd_word_t word;
    logic hit;
    logic [3:0] chanHot;
    assign grp = frameWord[`QDWFD_GRP_HI:`QDWFD_GRP_LO];
    assign csel = frameWord[`QDWFD_CSEL_HI:`QDWFD_CSEL_LO];
    assign chan = frameWord[`QDWFD_CH_HI:`QDWFD_CH_LO];
    assign word = frameWord[`QDWFD_DATA_HI:0];
    // address match against synchronised straps, write flag low
    assign hit = frameValid && !frameWord[`QDWFD_RW_BIT]
        && (frameWord[`QDWFD_TADDR_HI:`QDWFD_TADDR_LO] == st_q.strapSync2);
    assign chanHot = 4'h1 << chan;

    // per-channel write strobes
    always_comb begin
        wrData = 4'h0;
        wrGain = 4'h0;
        wrOffs = 4'h0;
        wrClr = 4'h0;
        wrDacCtl = 4'h0;
        wrSlew = 4'h0;
        if (hit) begin
            // broadcast groups ignore the channel bits
            case (grp)
                `QDWFD_GRP_DATA: wrData = chanHot;
                `QDWFD_GRP_GAIN: wrGain = chanHot;
                `QDWFD_GRP_GAIN_ALL: wrGain = 4'hf;
                `QDWFD_GRP_OFFS: wrOffs = chanHot;
                `QDWFD_GRP_OFFS_ALL: wrOffs = 4'hf;
                `QDWFD_GRP_CLR: wrClr = chanHot;
                `QDWFD_GRP_CTRL: begin
                    case (csel)
                        `QDWFD_CSEL_SLEW: wrSlew = chanHot;
                        `QDWFD_CSEL_DACCTL: wrDacCtl = chanHot;
                        default: begin
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    // one register set per channel, channel A at index 0
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            qdwfd_channel u_chan (
                .mclk(mclk),
                .reset_n(reset_n),
                .wrData(wrData[gi]),
                .wrGain(wrGain[gi]),
                .wrOffs(wrOffs[gi]),
                .wrClr(wrClr[gi]),
                .wrDacCtl(wrDacCtl[gi]),
                .wrSlew(wrSlew[gi]),
                .wrWord(word),
                .dataVal(dataVal[gi]),
                .gainVal(gainVal[gi]),
                .offsVal(offsVal[gi]),
                .clrVal(clrVal[gi]),
                .dacCtlVal(dacCtlVal[gi]),
                .slewVal(slewVal[gi])
            );
        end
    endgenerate

    // shared registers, synchronisers and output stage
    always_comb begin
        st_d = st_q;
        // two-flop synchronisers for the strap and clear pins
        st_d.strapSync1 = {addressStrapHi, addressStrapLo};
        st_d.strapSync2 = st_q.strapSync1;
        st_d.clrSync1 = clearPin;
        st_d.clrSync2 = st_q.clrSync1;
        // the software strobe stands for one cycle only
        st_d.swPulse = 1'b0;
        // shared control registers; undefined selects fall through unchanged
        if (hit && grp == `QDWFD_GRP_CTRL) begin
            case (csel)
                `QDWFD_CSEL_MAIN: st_d.mainCtl = word & `QDWFD_MAIN_MASK;
                `QDWFD_CSEL_DCDC: st_d.dcdc = word[`QDWFD_CDATA_HI:0];
                `QDWFD_CSEL_SW: begin
                    st_d.sw = word[`QDWFD_CDATA_HI:0];
                    st_d.swPulse = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // channel outputs are re-registered here, one edge behind the channel
        for (int i = 0; i < 4; i++) begin
            // clear forces the clear code where the channel enables it
            if (st_q.clrSync2 && dacCtlVal[i][`QDWFD_CLREN_BIT]) begin
                st_d.outCode[i*16 +: 16] = clrVal[i];
            end else begin
                st_d.outCode[i*16 +: 16] = dataVal[i];
            end
            st_d.gain[i*16 +: 16] = gainVal[i];
            st_d.offs[i*16 +: 16] = offsVal[i];
            st_d.dacCtl[i*16 +: 16] = {3'h0, dacCtlVal[i]};
            st_d.slew[i*16 +: 16] = {3'h0, slewVal[i]};
        end
    end

    // register stage; the synchronisers clear in reset and refill after it
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.mainCtl <= `QDWFD_MAIN_RST;
            st_q.gain <= {4{`QDWFD_GAIN_RST}};
            st_q.offs <= {4{`QDWFD_OFFS_RST}};
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flip-flops
    assign chanOutCode = st_q.outCode;
    assign chanGain = st_q.gain;
    assign chanOffset = st_q.offs;
    assign chanDacCtl = st_q.dacCtl;
    assign chanSlew = st_q.slew;
    assign outputPolarityOption = st_q.mainCtl[`QDWFD_MAIN_POLARITY];
    assign statusReadbackEnable = st_q.mainCtl[`QDWFD_MAIN_READBACK];
    assign watchdogEnableBit = st_q.mainCtl[`QDWFD_MAIN_WDOG];
    assign timeoutSelect = st_q.mainCtl[`QDWFD_MAIN_TSEL_HI:`QDWFD_MAIN_TSEL_LO];
    assign shortLimitSelect = st_q.mainCtl[`QDWFD_MAIN_SHORT];
    assign outputEnableAllChannels = st_q.mainCtl[`QDWFD_MAIN_OUTEN];
    assign converterPowerAllChannels = st_q.mainCtl[`QDWFD_MAIN_PWR];
    assign converterCtl = st_q.dcdc;
    assign softwareReg = st_q.sw;
    assign softwareWritePulse = st_q.swPulse;
endmodule

// >>> qdwfd_host_model.sv
// Purpose: host side that hands complete write frames to the decoder
// Assumes: one frame per call, launched 1 ns after a rising mclk edge
// Notes: a released word is inverted so stale bits never look like a frame
`timescale 1ns/1ps
module qdwfd_host_model (
    // clock
    input wire logic mclk,
    // frame output
    output logic frameValid,
    output logic [23:0] frameWord
);
    // idle at time zero
    initial begin
        frameValid = 1'b0;
        frameWord = 24'h0;
    end
    // present one frame and hold it across the taking edge
    task automatic send(input logic rw, input logic [1:0] addr, input logic [2:0] grp,
                        input logic [1:0] ch, input logic [15:0] dat);
        frameWord = {rw, addr, grp, ch, dat};
        frameValid = 1'b1;
        @(posedge mclk);
        #1;
    endtask
    // release the frame lines
    task automatic idle;
        frameValid = 1'b0;
        frameWord = ~frameWord;
    endtask
endmodule

// >>> qdwfd_top_sva.sv
// Purpose: timing checks on the frame decoder ports
// Assumes: strap pins stay constant, so the raw levels equal the synced ones
// Notes: channel outputs show two edges after the taking edge
`timescale 1ns/1ps
module qdwfd_top_sva (
    // clock, reset, frame and pins
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic frameValid,
    input wire logic [23:0] frameWord,
    input wire logic addressStrapHi,
    input wire logic addressStrapLo,
    input wire logic clearPin,
    // observed outputs
    input wire logic [63:0] chanOutCode,
    input wire logic [63:0] chanGain,
    input wire logic [63:0] chanOffset,
    input wire logic outputPolarityOption,
    input wire logic statusReadbackEnable,
    input wire logic watchdogEnableBit,
    input wire logic [1:0] timeoutSelect,
    input wire logic shortLimitSelect,
    input wire logic outputEnableAllChannels,
    input wire logic converterPowerAllChannels,
    input wire logic [12:0] converterCtl,
    input wire logic [12:0] softwareReg,
    input wire logic softwareWritePulse
);
    logic take;
    logic [2:0] grp;
    logic [1:0] ch;
    logic [15:0] dat;
    logic [7:0] mainOut;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // frame fields and the accepted-frame condition
    assign take = frameValid && !frameWord[23] && frameWord[22:21] == {addressStrapHi, addressStrapLo};
    assign grp = frameWord[20:18];
    assign ch = frameWord[17:16];
    assign dat = frameWord[15:0];
    assign mainOut = {outputPolarityOption, statusReadbackEnable, watchdogEnableBit, timeoutSelect,
                      shortLimitSelect, outputEnableAllChannels, converterPowerAllChannels};
    reset_vals_a: assert property ($rose(reset_n) |-> chanGain == {4{16'hffff}} && chanOffset == {4{16'h8000}})
        else $error("reset values wrong");
    gain_load_a: assert property (take && grp == 3'h2 |-> ##2 chanGain[16*$past(ch, 2) +: 16] == $past(dat, 2))
        else $error("gain word not loaded");
    gain_all_a: assert property (take && grp == 3'h3 |-> ##2 chanGain == {4{$past(dat, 2)}})
        else $error("gain broadcast missed");
    offset_load_a: assert property (take && grp == 3'h4 |-> ##2 chanOffset[16*$past(ch, 2) +: 16] == $past(dat, 2))
        else $error("offset word not loaded");
    offset_all_a: assert property (take && grp == 3'h5 |-> ##2 chanOffset == {4{$past(dat, 2)}})
        else $error("offset broadcast missed");
    data_load_a: assert property (take && grp == 3'h0 && !clearPin && !$past(clearPin)
                                  |-> ##2 chanOutCode[16*$past(ch, 2) +: 16] == $past(dat, 2))
        else $error("data word not loaded");
    main_fields_a: assert property (take && grp == 3'h7 && dat[15:13] == 3'h1
                                    |=> mainOut == {$past(dat[12:8]), $past(dat[6:4])})
        else $error("main control fields wrong");
    soft_write_a: assert property (take && grp == 3'h7 && dat[15:13] == 3'h4
                                   |=> softwareWritePulse && softwareReg == $past(dat[12:0]))
        else $error("software register write wrong");
    bad_select_a: assert property (take && grp == 3'h7 && dat[15:13] > 3'h4
                                   |=> $stable(mainOut) && $stable(converterCtl) && $stable(softwareReg))
        else $error("undefined select changed a register");
    addr_miss_a: assert property (frameValid && frameWord[22:21] != {addressStrapHi, addressStrapLo}
                                  |-> ##2 $stable(chanGain) && $stable(chanOffset))
        else $error("frame for another address changed a register");
endmodule
bind qdwfd_top qdwfd_top_sva u_sva (.mclk, .reset_n, .frameValid, .frameWord, .addressStrapHi, .addressStrapLo,
    .clearPin, .chanOutCode, .chanGain, .chanOffset, .outputPolarityOption, .statusReadbackEnable,
    .watchdogEnableBit, .timeoutSelect, .shortLimitSelect, .outputEnableAllChannels, .converterPowerAllChannels,
    .converterCtl, .softwareReg, .softwareWritePulse);

// >>> quad_dac_write_frame_decoder_test.sv
// Purpose: directed frame sequences against the decoder
// Assumes: straps read 10, so frames address 2'h2
// Notes: channel results are read two edges after the taking edge
`timescale 1ns/1ps
module quad_dac_write_frame_decoder_test;
    import qdwfd_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic clearPin = 1'b0;
    logic strapHi = 1'b1;
    logic strapLo = 1'b0;
    logic frameValid;
    logic [23:0] frameWord;
    logic [63:0] outCode, gain, offs, dacCtl, slew;
    logic pol, stat, wde, shl, oen, cpw, swp;
    logic [1:0] tsel;
    logic [12:0] cnv, swr;
    int err_count = 0;
    int checks_done = 0;
    // clock and units under test
    initial forever #12.5 mclk = ~mclk;
    qdwfd_host_model host (.mclk(mclk), .frameValid(frameValid), .frameWord(frameWord));
    qdwfd_top DUT (.mclk(mclk), .reset_n(reset_n), .frameValid(frameValid), .frameWord(frameWord),
        .addressStrapHi(strapHi), .addressStrapLo(strapLo), .clearPin(clearPin), .chanOutCode(outCode),
        .chanGain(gain), .chanOffset(offs), .chanDacCtl(dacCtl), .chanSlew(slew), .outputPolarityOption(pol),
        .statusReadbackEnable(stat), .watchdogEnableBit(wde), .timeoutSelect(tsel), .shortLimitSelect(shl),
        .outputEnableAllChannels(oen), .converterPowerAllChannels(cpw), .converterCtl(cnv),
        .softwareReg(swr), .softwareWritePulse(swp));
    // comparison and bookkeeping
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [2:0] grp, input logic [1:0] ch, input logic [15:0] dat);
        host.send(1'b0, 2'h2, grp, ch, dat);
        host.idle();
        settle(2);
    endtask
    task automatic summarize;
        $display("errors=%0d checks=%0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        #20000;
        err_count++;
        summarize();
    end
    // main sequence
    initial begin
        settle(3);
        reset_n = 1'b1;
        settle(3);
        chk(gain, {4{16'hffff}});
        chk(offs, {4{16'h8000}});
        chk(outCode, 64'h0);
        for (int i = 0; i < 4; i++) begin
            wr(3'h0, i[1:0], 16'h1100 + 16'(i));
        end
        chk(outCode, 64'h1103_1102_1101_1100);
        wr(3'h3, 2'h2, 16'h7777);
        chk(gain, {4{16'h7777}});
        wr(3'h2, 2'h1, 16'h1234);
        chk(gain, 64'h7777_7777_1234_7777);
        wr(3'h5, 2'h0, 16'h0001);
        chk(offs, {4{16'h0001}});
        wr(3'h4, 2'h3, 16'hffff);
        chk(offs, 64'hffff_0001_0001_0001);
        host.send(1'b1, 2'h2, 3'h2, 2'h0, 16'h0bad);
        host.send(1'b0, 2'h1, 3'h2, 2'h0, 16'h0bad);
        host.idle();
        settle(2);
        chk(gain, 64'h7777_7777_1234_7777);
        host.send(1'b0, 2'h2, 3'h2, 2'h2, 16'haaaa);
        host.send(1'b0, 2'h2, 3'h2, 2'h3, 16'hbbbb);
        host.idle();
        settle(2);
        chk(gain, 64'hbbbb_aaaa_1234_7777);
        wr(3'h7, 2'h0, {3'h1, 13'h1fff});
        chk({56'h0, pol, stat, wde, tsel, shl, oen, cpw}, 64'hff);
        wr(3'h7, 2'h0, {3'h1, 13'h0ad5});
        chk({56'h0, pol, stat, wde, tsel, shl, oen, cpw}, 64'h55);
        wr(3'h7, 2'h3, {3'h0, 13'h1abc});
        chk(slew, {3'h0, 13'h1abc, 48'h0});
        wr(3'h7, 2'h0, {3'h2, 13'h0001});
        chk(dacCtl, 64'h1);
        wr(3'h7, 2'h0, {3'h3, 13'h0123});
        chk({51'h0, cnv}, 64'h123);
        host.send(1'b0, 2'h2, 3'h7, 2'h0, {3'h4, 13'h0456});
        chk({63'h0, swp}, 64'h1);
        host.idle();
        settle(2);
        chk({51'h0, swr}, 64'h456);
        chk({63'h0, swp}, 64'h0);
        wr(3'h7, 2'h0, {3'h5, 13'h1111});
        wr(3'h7, 2'h0, {3'h7, 13'h1111});
        chk({38'h0, swr, cnv}, {38'h0, 13'h0456, 13'h0123});
        wr(3'h6, 2'h0, 16'h1357);
        wr(3'h6, 2'h2, 16'h2468);
        clearPin = 1'b1;
        settle(5);
        chk(outCode, 64'h1103_1102_1101_1357);
        clearPin = 1'b0;
        settle(5);
        chk(outCode, 64'h1103_1102_1101_1100);
        summarize();
    end
endmodule
